// *** common/acefm_pkg.sv ***
`default_nettype none
package acefm_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SRC_LO = 8'h04;
  localparam logic [7:0] OFS_SRC_HI = 8'h08;
  localparam logic [7:0] OFS_DST_LO = 8'h0c;
  localparam logic [7:0] OFS_DST_HI = 8'h10;
  localparam logic [7:0] OFS_VLAN = 8'h14;
  localparam logic [7:0] OFS_SND_IP = 8'h18;
  localparam logic [7:0] OFS_SND_IP_MASK = 8'h1c;
  localparam logic [7:0] OFS_TIP = 8'h20;
  localparam logic [7:0] OFS_TIP_MASK = 8'h24;
  localparam logic [7:0] OFS_STATUS = 8'h28;
  // control field positions
  localparam int CTL_FTYPE = 0;   // 2 bits
  localparam int CTL_SRC = 2;     // 1 bit
  localparam int CTL_DST = 3;     // 3 bits
  localparam int CTL_VID = 6;     // 1 bit
  localparam int CTL_PRIEN = 7;   // 1 bit
  localparam int CTL_PRI = 8;     // 3 bits
  localparam int CTL_OPC = 11;    // 2 bits
  localparam int CTL_REQ = 13;    // 2 bits
  localparam int CTL_SIPM = 15;   // 2 bits
  localparam int CTL_TIPM = 17;   // 2 bits
  localparam int CTL_SHA = 19;    // 2 bits
  localparam int CTL_WIDTH = 21;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // frame types
  typedef enum logic [1:0] {FT_ANY = 2'h0, FT_ETYPE = 2'h1, FT_ARP = 2'h3,
    FT_IPV4 = 2'h2} acefm_ftype_t;
  // destination class selections
  typedef enum logic [2:0] {DST_ANY = 3'h0, DST_MCAST = 3'h1, DST_BCAST = 3'h2,
    DST_UCAST = 3'h3, DST_SPEC = 3'h4} acefm_dst_t;
  typedef enum logic [1:0] {OPC_ANY = 2'h0, OPC_ARP = 2'h1, OPC_RARP = 2'h2,
    OPC_OTHER = 2'h3} acefm_opc_t;
  typedef enum logic [1:0] {RR_ANY = 2'h0, RR_REQ = 2'h1, RR_REPLY = 2'h2} acefm_rr_t;
  typedef enum logic [1:0] {IPM_ANY = 2'h0, IPM_HOST = 2'h1, IPM_NET = 2'h2} acefm_ipm_t;
  typedef enum logic [1:0] {SHA_ANY = 2'h0, SHA_DIFF = 2'h1, SHA_EQ = 2'h2} acefm_sha_t;
  // frame opcode class from ingress
  typedef enum logic [1:0] {FOP_ARP = 2'h0, FOP_RARP = 2'h1, FOP_OTHER = 2'h3} acefm_fop_t;
  localparam logic [47:0] MAC_BCAST = 48'hffff_ffff_ffff;
  localparam logic [11:0] VID_MIN = 12'h001;
  localparam logic [11:0] VID_MAX = 12'hfff;
  // group bit: lowest bit of the first address octet
  localparam int MAC_GROUP_BIT = 40;
  // hit counter saturates here
  localparam logic [15:0] HIT_CNT_MAX = 16'hffff;
endpackage
`default_nettype wire

// *** logic/acefm_ip_cmp.sv ***
`timescale 1ns/1ps
`default_nettype none
module acefm_ip_cmp
  import acefm_pkg::*;
(
  // selection
  input wire logic [1:0] mode,
  input wire logic [31:0] cfgAddr,
  input wire logic [31:0] cfgMask,
  // frame field
  input wire logic [31:0] frameAddr,
  // result
  output logic pass
);
  // any passes, host full compare, network masked compare
  always_comb begin
    case (mode)
      IPM_HOST: pass = (frameAddr == cfgAddr);
      IPM_NET: pass = ((frameAddr ^ cfgAddr) & cfgMask) == 32'h0000_0000;
      default: pass = 1'b1;
    endcase
  end
endmodule
`default_nettype wire

// *** logic/acefm_match.sv ***
// Function
// [RULE_01] source check only for ethertype or ARP
// [RULE_02] source any never blocks hit
// [RULE_03] source specific needs exact address
// [RULE_04] destination any ignores destination
// [RULE_05] destination multicast, broadcast, unicast classes
// [RULE_06] destination specific needs exact address
// [RULE_07] VLAN any ignores VLAN ID
// [RULE_08] VLAN specific 1..4095 exact compare
// [RULE_09] priority any or exact 0..7
// [RULE_10] ARP criteria only for ARP entries
// [RULE_11] opcode: any, ARP, RARP, other
// [RULE_12] request/reply: any, request, reply
// [RULE_13] sender IP host or any
// [RULE_14] sender IP network masked compare
// [RULE_15] target IP host or any
// [RULE_16] target IP network masked compare
// [RULE_17] sender hardware address criterion exists
// [RULE_18] sender hw: differ, equal, any
// [RULE_19] hit needs every enabled criterion
//
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module acefm_match
  import acefm_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // frame from ingress
  input wire logic frameValid,
  input wire logic [47:0] frameSourceAddress,
  input wire logic [47:0] frameDestinationAddress,
  input wire logic [11:0] frameVlanId,
  input wire logic [2:0] framePriority,
  input wire logic [1:0] frameType,
  input wire logic [1:0] arpOpcodeField,
  input wire logic arpIsReply,
  input wire logic [31:0] senderIpField,
  input wire logic [31:0] targetIpField,
  input wire logic [47:0] senderHwAddress,
  // result to ingress
  output logic hitValid,
  output logic hit
);
  // -----------------------------------------------------------------
  // state
  // -----------------------------------------------------------------
  typedef struct packed {
    logic [CTL_WIDTH-1:0] ctrl;
    logic [47:0] srcAddr;
    logic [47:0] dstAddr;
    logic [11:0] vid;
    logic [31:0] sndIp;
    logic [31:0] sndIpMask;
    logic [31:0] tip;
    logic [31:0] tipMask;
    logic wrPend;
    logic [7:0] wrAddr;
    logic [31:0] rdata;
    logic hitValid;
    logic hit;
    logic [15:0] hitCount;
  } acefm_state_t;

  acefm_state_t s_q, s_d;
  logic sndIpPass, tipPass;
  logic srcPass, dstPass, vidPass, priPass, opcPass, rrPass, shaPass, arpPass;
  logic hitNow, opKnown;
  logic [7:0] aOfs;
  logic [31:0] rdMux;

  // -----------------------------------------------------------------
  // ip comparators
  // -----------------------------------------------------------------
  acefm_ip_cmp u_sender_ip (
    .mode(s_q.ctrl[CTL_SIPM +: 2]),
    .cfgAddr(s_q.sndIp),
    .cfgMask(s_q.sndIpMask),
    .frameAddr(senderIpField),
    .pass(sndIpPass)
  ); // [RULE_13] [RULE_14]
  acefm_ip_cmp u_tip (
    .mode(s_q.ctrl[CTL_TIPM +: 2]),
    .cfgAddr(s_q.tip),
    .cfgMask(s_q.tipMask),
    .frameAddr(targetIpField),
    .pass(tipPass)
  ); // [RULE_15] [RULE_16]

  // -----------------------------------------------------------------
  // criteria evaluation
  // -----------------------------------------------------------------
  always_comb begin
    logic [1:0] ft;
    ft = s_q.ctrl[CTL_FTYPE +: 2];
    // source filter shown only for ethertype and ARP entries
    srcPass = 1'b1; // [RULE_02]
    if ((ft == FT_ETYPE || ft == FT_ARP) && s_q.ctrl[CTL_SRC]) begin // [RULE_01]
      srcPass = (frameSourceAddress == s_q.srcAddr); // [RULE_03]
    end
    // bit 0 of first octet is the group bit
    case (s_q.ctrl[CTL_DST +: 3])
      DST_MCAST: dstPass = frameDestinationAddress[MAC_GROUP_BIT] &&
        (frameDestinationAddress != MAC_BCAST); // [RULE_05]
      DST_BCAST: dstPass = (frameDestinationAddress == MAC_BCAST); // [RULE_05]
      DST_UCAST: dstPass = !frameDestinationAddress[MAC_GROUP_BIT]; // [RULE_05]
      DST_SPEC: dstPass = (frameDestinationAddress == s_q.dstAddr); // [RULE_06]
      default: dstPass = 1'b1; // [RULE_04]
    endcase
    vidPass = !s_q.ctrl[CTL_VID] || (frameVlanId == s_q.vid); // [RULE_07] [RULE_08]
    priPass = !s_q.ctrl[CTL_PRIEN] ||
      (framePriority == s_q.ctrl[CTL_PRI +: 3]); // [RULE_09]
    case (s_q.ctrl[CTL_OPC +: 2])
      OPC_ARP: opcPass = (arpOpcodeField == FOP_ARP); // [RULE_11]
      OPC_RARP: opcPass = (arpOpcodeField == FOP_RARP); // [RULE_11]
      OPC_OTHER: opcPass = (arpOpcodeField != FOP_ARP) &&
        (arpOpcodeField != FOP_RARP); // [RULE_11]
      default: opcPass = 1'b1;
    endcase
    // request/reply only meaningful for known opcodes
    opKnown = (arpOpcodeField == FOP_ARP) || (arpOpcodeField == FOP_RARP);
    case (s_q.ctrl[CTL_REQ +: 2])
      RR_REQ: rrPass = opKnown && !arpIsReply; // [RULE_12]
      RR_REPLY: rrPass = opKnown && arpIsReply; // [RULE_12]
      default: rrPass = 1'b1;
    endcase
    case (s_q.ctrl[CTL_SHA +: 2])
      SHA_DIFF: shaPass = (senderHwAddress != frameSourceAddress); // [RULE_17] [RULE_18]
      SHA_EQ: shaPass = (senderHwAddress == frameSourceAddress); // [RULE_18]
      default: shaPass = 1'b1;
    endcase
    // ARP group ignored unless the entry is an ARP entry
    arpPass = (ft != FT_ARP) ||
      (opcPass && rrPass && sndIpPass && tipPass && shaPass); // [RULE_10]
    // entry frame type must agree with the frame
    hitNow = ((ft == FT_ANY) || (ft == frameType)) && srcPass && dstPass &&
      vidPass && priPass && arpPass; // [RULE_19]
  end

  // -----------------------------------------------------------------
  // register read mux
  // -----------------------------------------------------------------
  always_comb begin
    aOfs = haddr[7:0];
    case (aOfs)
      OFS_CTRL: rdMux = {{(32-CTL_WIDTH){1'b0}}, s_q.ctrl};
      OFS_SRC_LO: rdMux = s_q.srcAddr[31:0];
      OFS_SRC_HI: rdMux = {16'h0000, s_q.srcAddr[47:32]};
      OFS_DST_LO: rdMux = s_q.dstAddr[31:0];
      OFS_DST_HI: rdMux = {16'h0000, s_q.dstAddr[47:32]};
      OFS_VLAN: rdMux = {20'h00000, s_q.vid};
      OFS_SND_IP: rdMux = s_q.sndIp;
      OFS_SND_IP_MASK: rdMux = s_q.sndIpMask;
      OFS_TIP: rdMux = s_q.tip;
      OFS_TIP_MASK: rdMux = s_q.tipMask;
      OFS_STATUS: rdMux = {15'h0000, s_q.hit, s_q.hitCount};
      default: rdMux = 32'h0000_0000; // unmapped reads zero, OKAY
    endcase
  end

  // -----------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------
  always_comb begin
    logic take;
    take = hsel && hready && htrans[1];
    s_d = s_q;
    // pending write lands in data phase
    if (s_q.wrPend) begin
      case (s_q.wrAddr)
        OFS_CTRL: s_d.ctrl = hwdata[CTL_WIDTH-1:0];
        OFS_SRC_LO: s_d.srcAddr[31:0] = hwdata;
        OFS_SRC_HI: s_d.srcAddr[47:32] = hwdata[15:0];
        OFS_DST_LO: s_d.dstAddr[31:0] = hwdata;
        OFS_DST_HI: s_d.dstAddr[47:32] = hwdata[15:0];
        OFS_VLAN: begin
          // zero is refused so the held identifier stays in range
          if (hwdata[11:0] >= VID_MIN && hwdata[11:0] <= VID_MAX) begin
            s_d.vid = hwdata[11:0]; // [RULE_08]
          end
        end
        OFS_SND_IP: s_d.sndIp = hwdata;
        OFS_SND_IP_MASK: s_d.sndIpMask = hwdata;
        OFS_TIP: s_d.tip = hwdata;
        OFS_TIP_MASK: s_d.tipMask = hwdata;
        OFS_STATUS: s_d.hitCount = 16'h0000; // write clears counter
        default: ;
      endcase
    end
    s_d.wrPend = take && hwrite;
    s_d.wrAddr = take ? haddr[7:0] : s_q.wrAddr;
    if (take && !hwrite) begin
      s_d.rdata = rdMux;
    end
    // one result per frame, one cycle later
    s_d.hitValid = frameValid;
    if (frameValid) begin
      s_d.hit = hitNow; // [RULE_19]
      if (hitNow && s_d.hitCount != HIT_CNT_MAX) begin // clear plus hit counts one
        s_d.hitCount = s_d.hitCount + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      s_q <= '0;
      s_q.ctrl <= CTRL_RESET[CTL_WIDTH-1:0];
      s_q.vid <= VID_MIN;
    end else begin
      s_q <= s_d;
    end
  end

  // hrdata and results straight from flops, hreadyout and hresp tied off; zero wait states
  assign hrdata = s_q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hitValid = s_q.hitValid;
  assign hit = s_q.hit;

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  a_src_specific: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE_03]
    frameValid && s_q.ctrl[CTL_SRC] && s_q.ctrl[CTL_FTYPE +: 2] == FT_ETYPE &&
    frameSourceAddress != s_q.srcAddr |=> !hit)
    else $error("source mismatch produced a hit");
  a_dst_bcast: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE_05]
    frameValid && s_q.ctrl[CTL_DST +: 3] == DST_BCAST &&
    frameDestinationAddress != MAC_BCAST |=> !hit)
    else $error("broadcast class passed non-broadcast");
  a_dst_spec: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE_06]
    frameValid && s_q.ctrl[CTL_DST +: 3] == DST_SPEC &&
    frameDestinationAddress != s_q.dstAddr |=> !hit)
    else $error("destination mismatch produced a hit");
  a_vid_range: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE_08]
    s_q.vid != 12'h000)
    else $error("held vlan id out of range");
  a_pri_match: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE_09]
    frameValid && s_q.ctrl[CTL_PRIEN] && framePriority != s_q.ctrl[CTL_PRI +: 3] |=> !hit)
    else $error("priority mismatch produced a hit");
  a_arp_ignored: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE_10]
    frameValid && s_q.ctrl[CTL_FTYPE +: 2] == FT_ANY && s_q.ctrl[CTL_SRC +: 6] == 6'h00 &&
    !s_q.ctrl[CTL_VID] && !s_q.ctrl[CTL_PRIEN] |=> hit)
    else $error("don't-care entry missed a frame");
  a_sender_net: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE_14]
    frameValid && s_q.ctrl[CTL_FTYPE +: 2] == FT_ARP && s_q.ctrl[CTL_SIPM +: 2] == IPM_NET &&
    ((senderIpField ^ s_q.sndIp) & s_q.sndIpMask) != 32'h0 |=> !hit)
    else $error("sender network mismatch produced a hit");
  a_sha_eq: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE_18]
    frameValid && s_q.ctrl[CTL_FTYPE +: 2] == FT_ARP && s_q.ctrl[CTL_SHA +: 2] == SHA_EQ &&
    senderHwAddress != frameSourceAddress |=> !hit)
    else $error("sender hw equality violated");
  a_hit_valid: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE_19]
    !frameValid |=> !hitValid ##0 $stable(hit))
    else $error("result changed without a frame");
  a_req_known: assert property (@(posedge core_clk) disable iff (sys_rst) // [RULE_12]
    frameValid && s_q.ctrl[CTL_FTYPE +: 2] == FT_ARP && s_q.ctrl[CTL_REQ +: 2] == RR_REQ &&
    arpOpcodeField != FOP_ARP && arpOpcodeField != FOP_RARP |=> !hit)
    else $error("request criterion passed an unknown opcode");
endmodule
`default_nettype wire

// *** testbench/acefm_ingress_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module acefm_ingress_model (
  // clock
  input wire logic core_clk,
  // frame fields packed by the bench
  input wire logic [227:0] fld,
  // frame to the entry
  output logic frameValid,
  output logic [47:0] frameSourceAddress,
  output logic [47:0] frameDestinationAddress,
  output logic [11:0] frameVlanId,
  output logic [2:0] framePriority,
  output logic [1:0] frameType,
  output logic [1:0] arpOpcodeField,
  output logic arpIsReply,
  output logic [31:0] senderIpField,
  output logic [31:0] targetIpField,
  output logic [47:0] senderHwAddress,
  // verdict back
  input wire logic hitValid,
  input wire logic hit
);
  // inverted outside the valid cycle so a stale field never matches by luck
  assign {frameSourceAddress, frameDestinationAddress, frameVlanId, framePriority, frameType,
    arpOpcodeField, arpIsReply, senderIpField, targetIpField, senderHwAddress} =
    frameValid ? fld : ~fld;
  // idle until asked
  initial begin
    frameValid = 1'b0;
  end
  // one frame, verdict awaited a few cycles at most
  task automatic send(output logic ok, output logic got);
    int n;
    @(posedge core_clk);
    frameValid <= 1'b1;
    @(posedge core_clk);
    frameValid <= 1'b0;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hitValid !== 1'b1 && n < 4);
    ok = hitValid;
    got = hit;
  endtask
endmodule
`default_nettype wire

// *** testbench/test_acefm_match.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_acefm_match;
  import acefm_pkg::*;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic frameValid;
  logic [47:0] fs, fd, fh;
  logic [11:0] v = 12'h001;
  logic [2:0] p = 3'h0;
  logic [1:0] ft = 2'h0;
  logic [1:0] opc = 2'h0;
  logic rp = 1'b0;
  logic [31:0] si = 32'h0;
  logic [31:0] ti = 32'h0;
  logic [47:0] fsrc, fdst, fsha;
  logic [11:0] fvid;
  logic [2:0] fpri;
  logic [1:0] ftyp, fopc;
  logic frep, hitValid, hit;
  logic [31:0] fsip, ftip;
  int miscompares = 0;
  int testsRun = 0;
  // multicast, broadcast, configured unicast, other unicast; bit a of dExp[sel] is the verdict
  logic [47:0] dAdr [4] = '{48'h0100_5e00_0001, MAC_BCAST, 48'h0011_2233_4455,
    48'h0011_2233_4456};
  logic [3:0] dExp [5] = '{4'hf, 4'h1, 4'h2, 4'hc, 4'h4};
  logic [31:0] ipA [3] = '{32'h0a00_0001, 32'h0a00_00fe, 32'h0a00_01fe};
  logic [2:0] ipExp [3] = '{3'h7, 3'h1, 3'h3};

  acefm_match u_acefm_match (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .frameValid(frameValid), .frameSourceAddress(fsrc), .frameDestinationAddress(fdst),
    .frameVlanId(fvid), .framePriority(fpri), .frameType(ftyp), .arpOpcodeField(fopc),
    .arpIsReply(frep), .senderIpField(fsip), .targetIpField(ftip), .senderHwAddress(fsha),
    .hitValid(hitValid), .hit(hit));
  acefm_ingress_model u_acefm_ingress_model (.core_clk(core_clk),
    .fld({fs, fd, v, p, ft, opc, rp, si, ti, fh}), .frameValid(frameValid),
    .frameSourceAddress(fsrc), .frameDestinationAddress(fdst), .frameVlanId(fvid),
    .framePriority(fpri), .frameType(ftyp), .arpOpcodeField(fopc), .arpIsReply(frep),
    .senderIpField(fsip), .targetIpField(ftip), .senderHwAddress(fsha),
    .hitValid(hitValid), .hit(hit));

  always #5 core_clk = ~core_clk;

  // ----------------------------------------
  // bus and frame helpers
  // ----------------------------------------
  task automatic close_out();
    $display("checks %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // single word transfer; hready is sampled, never assumed
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    hsize <= 3'h2;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge core_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    rd = hrdata;
    if (n >= 40) begin
      miscompares++;
      close_out();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    testsRun++;
    if (r !== e || hresp !== 1'b0) begin
      miscompares++;
      $display("MISMATCH %0t read %h want %h", $time, r, e);
    end
  endtask
  // control word: entry frame type plus one field
  task automatic cf(input logic [1:0] t, input logic [31:0] f, input int pos);
    wr(OFS_CTRL, {30'h0, t} | (f << pos));
  endtask
  task automatic fr(input logic e);
    logic ok, got;
    u_acefm_ingress_model.send(ok, got);
    testsRun++;
    if (ok !== 1'b1) begin
      miscompares++;
      close_out();
    end
    if (got !== e) begin
      miscompares++;
      $display("MISMATCH %0t hit %b want %b", $time, got, e);
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    fs = 48'h0;
    fd = dAdr[2];
    fh = 48'h0;
    repeat (4) @(posedge core_clk);
    sys_rst <= 1'b0;
    rc(OFS_CTRL, CTRL_RESET);
    rc(OFS_VLAN, {20'h0, VID_MIN});
    wr(8'h2c, 32'h1234_5678);
    rc(8'h2c, 32'h0);
    fr(1'b1);
    rc(OFS_STATUS, 32'h0001_0001);
    wr(OFS_STATUS, 32'h0);
    rc(OFS_STATUS, 32'h0001_0000);
    cf(FT_ETYPE, 32'h0, 0);
    ft <= FT_IPV4;
    fr(1'b0);
    wr(OFS_SRC_LO, 32'h2233_4455);
    wr(OFS_SRC_HI, 32'h0000_0011);
    cf(FT_ETYPE, 32'h1, CTL_SRC);
    ft <= FT_ETYPE;
    fs <= 48'h0011_2233_4455;
    fr(1'b1);
    fs <= 48'h0011_2233_4454;
    fr(1'b0);
    cf(FT_IPV4, 32'h1, CTL_SRC);
    ft <= FT_IPV4;
    fr(1'b1);
    ft <= FT_ANY;
    wr(OFS_DST_LO, 32'h2233_4455);
    wr(OFS_DST_HI, 32'h0000_0011);
    for (int k = 0; k < 5; k++) begin
      cf(FT_ANY, 32'(k), CTL_DST);
      for (int a = 0; a < 4; a++) begin
        fd <= dAdr[a];
        fr(dExp[k][a]);
      end
    end
    // a zero identifier must leave the old one in place
    wr(OFS_VLAN, 32'h0000_0fff);
    wr(OFS_VLAN, 32'h0);
    rc(OFS_VLAN, {20'h0, VID_MAX});
    cf(FT_ANY, 32'h1, CTL_VID);
    v <= VID_MAX;
    fr(1'b1);
    v <= VID_MIN;
    fr(1'b0);
    for (int k = 0; k < 8; k++) begin
      cf(FT_ANY, 32'(2 * k + 1), CTL_PRIEN);
      p <= 3'(k);
      fr(1'b1);
      p <= 3'(k ^ 1);
      fr(1'b0);
    end
    ft <= FT_ARP;
    for (int k = 1; k < 4; k++) begin
      cf(FT_ARP, 32'(k), CTL_OPC);
      for (int f = 0; f < 4; f++) begin
        opc <= 2'(f);
        fr((k == 1 && f == 0) || (k == 2 && f == 1) || (k == 3 && f >= 2));
      end
    end
    cf(FT_IPV4, 32'(OPC_ARP), CTL_OPC);
    ft <= FT_IPV4;
    opc <= FOP_RARP;
    fr(1'b1);
    ft <= FT_ARP;
    for (int k = 1; k < 3; k++) begin
      cf(FT_ARP, 32'(k), CTL_REQ);
      rp <= 1'b0;
      fr(k == 1);
      rp <= 1'b1;
      fr(k == 2);
    end
    // an unknown opcode is neither a request nor a reply
    cf(FT_ARP, 32'(RR_REQ), CTL_REQ);
    rp <= 1'b0;
    opc <= FOP_OTHER;
    fr(1'b0);
    opc <= FOP_RARP;
    wr(OFS_SND_IP, ipA[0]);
    wr(OFS_SND_IP_MASK, 32'hffff_ff00);
    wr(OFS_TIP, ipA[0]);
    wr(OFS_TIP_MASK, 32'hffff_ff00);
    // the idle address field carries zero, so a swapped field is caught
    for (int k = 0; k < 2; k++) begin
      for (int m = 0; m < 3; m++) begin
        cf(FT_ARP, 32'(m), k ? CTL_TIPM : CTL_SIPM);
        for (int a = 0; a < 3; a++) begin
          si <= k ? 32'h0 : ipA[a];
          ti <= k ? ipA[a] : 32'h0;
          fr(ipExp[m][a]);
        end
      end
    end
    for (int k = 0; k < 3; k++) begin
      cf(FT_ARP, 32'(k), CTL_SHA);
      fh <= fs;
      fr(k != 1);
      fh <= ~fs;
      fr(k != 2);
    end
    close_out();
  end
endmodule
`default_nettype wire
